/* include/bcd_out_pkg.sv */
// constants and carriers for the bcd result output port
// assumes a single 50 MHz clock; all timing is counted in whole milliseconds
package bcd_out_pkg;
    // clock and millisecond timebase
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    // output sequence times, in ms
    localparam int SETUP_MS = 30;
    localparam int VALID_MS = 40;
    localparam int RELEASE_MS = 16;
    localparam int PERIOD_MS = 64;
    localparam int GAP_MS = PERIOD_MS - VALID_MS;
    // least quiet time the reader leaves before a new request, in ms
    localparam int REQ_GAP_MS = 20;
    // width of the millisecond counter
    localparam int MS_W = 8;
    // number of bcd digits on the port
    localparam int DIGITS = 5;
    localparam int DATA_W = DIGITS * 4;

    // one open-collector line group: data strobe and bcd digits
    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } bcd_lines_t;

    // all transistors off
    localparam bcd_lines_t LINES_OFF = '0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_VALID,
        ST_GAP,
        ST_RELEASE
    } out_state_t;
endpackage

/* src/bcd_result_port.sv */
// bcd result port: request driven, timed open-collector output of a measurement
// assumes request and hold arrive asynchronously from pins, result from local logic
//
// Contract
// - data lines idle unless reader requests
// - data and strobe on about 30 ms after request
// - strobe off after 40 ms, data stable
// - data lines off 16 ms after strobe
// - held request repeats fresh value every 64 ms
// - hold gives old or new, never off
// - outputs are open collector, wired-or capable
// - request and hold inputs are active low
`timescale 1ns/1ns
`default_nettype none
module bcd_result_port #(
    parameter int MS_CYCLES = bcd_out_pkg::MS_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic request_n,
    input wire logic hold_n,
    input wire logic [bcd_out_pkg::DATA_W-1:0] meas_value,
    input wire bcd_out_pkg::bcd_lines_t lines_in,
    output var bcd_out_pkg::bcd_lines_t lines_out,
    output var bcd_out_pkg::bcd_lines_t lines_oe
);
    localparam int SETUP_CYC = bcd_out_pkg::SETUP_MS * MS_CYCLES;
    localparam int VALID_CYC = bcd_out_pkg::VALID_MS * MS_CYCLES;
    localparam int RELEASE_CYC = bcd_out_pkg::RELEASE_MS * MS_CYCLES;
    localparam int PERIOD_CYC = bcd_out_pkg::PERIOD_MS * MS_CYCLES;

    logic req_meta_ff, req_sync_ff, req_prev_ff;
    logic hold_meta_ff, hold_sync_ff;
    logic req_act, hold_act, req_rise;
    bcd_out_pkg::out_state_t state_ff, nxt_state;
    logic load;
    logic restart;
    logic [31:0] cyc_ff;
    logic [bcd_out_pkg::MS_W-1:0] ms_ff;
    logic [bcd_out_pkg::DATA_W-1:0] held_ff;
    bcd_out_pkg::bcd_lines_t oe_ff, out_ff;

    // true in the last cycle before the ms count reaches a target
    // leaving on that edge makes each phase exactly target ms long, not one cycle more
    function automatic logic ms_at(input logic [bcd_out_pkg::MS_W-1:0] ms,
        input logic [31:0] cyc, input int target);
        logic [31:0] last;
        last = 32'(target - 1);
        ms_at = (ms == last[bcd_out_pkg::MS_W-1:0]) && (cyc == 32'(MS_CYCLES - 1));
    endfunction

    // two-stage synchronisers for the pin inputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_meta_ff <= 1'b1;
            req_sync_ff <= 1'b1;
            req_prev_ff <= 1'b1;
            hold_meta_ff <= 1'b1;
            hold_sync_ff <= 1'b1;
        end else begin
            req_meta_ff <= request_n;
            req_sync_ff <= req_meta_ff;
            req_prev_ff <= req_sync_ff;
            hold_meta_ff <= hold_n;
            hold_sync_ff <= hold_meta_ff;
        end
    end

    // negative logic: a low pin means asserted
    assign req_act = ~req_sync_ff;
    assign hold_act = ~hold_sync_ff;
    assign req_rise = req_prev_ff & ~req_sync_ff;

    // sequencer next state
    always_comb begin
        nxt_state = state_ff;
        load = 1'b0;
        case (state_ff)
            bcd_out_pkg::ST_IDLE: begin
                if (req_rise) begin
                    nxt_state = bcd_out_pkg::ST_SETUP;
                end
            end
            bcd_out_pkg::ST_SETUP: begin
                if (ms_at(ms_ff, cyc_ff, bcd_out_pkg::SETUP_MS)) begin
                    nxt_state = bcd_out_pkg::ST_VALID;
                    load = 1'b1;
                end
            end
            bcd_out_pkg::ST_VALID: begin
                if (ms_at(ms_ff, cyc_ff, bcd_out_pkg::VALID_MS)) begin
                    nxt_state = req_act ? bcd_out_pkg::ST_GAP : bcd_out_pkg::ST_RELEASE;
                end
            end
            bcd_out_pkg::ST_GAP: begin
                if (ms_at(ms_ff, cyc_ff, bcd_out_pkg::GAP_MS)) begin
                    if (req_act) begin
                        nxt_state = bcd_out_pkg::ST_VALID;
                        load = 1'b1;
                    end else begin
                        nxt_state = bcd_out_pkg::ST_IDLE;
                    end
                end else if (!req_act && (ms_ff >= bcd_out_pkg::RELEASE_MS[bcd_out_pkg::MS_W-1:0]
                    || ms_at(ms_ff, cyc_ff, bcd_out_pkg::RELEASE_MS))) begin
                    nxt_state = bcd_out_pkg::ST_IDLE;
                end
            end
            bcd_out_pkg::ST_RELEASE: begin
                if (ms_at(ms_ff, cyc_ff, bcd_out_pkg::RELEASE_MS)) begin
                    nxt_state = bcd_out_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = bcd_out_pkg::ST_IDLE;
            end
        endcase
    end

    assign restart = (nxt_state != state_ff);

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= bcd_out_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // millisecond timebase, restarted on every state entry
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cyc_ff <= 32'h0000_0000;
            ms_ff <= '0;
        end else if (restart) begin
            cyc_ff <= 32'h0000_0000;
            ms_ff <= '0;
        end else if (cyc_ff == 32'(MS_CYCLES - 1)) begin
            cyc_ff <= 32'h0000_0000;
            ms_ff <= ms_ff + 1'b1;
        end else begin
            cyc_ff <= cyc_ff + 32'h0000_0001;
        end
    end

    // hold freezes the value that the next load will present
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            held_ff <= '0;
        end else if (!hold_act) begin
            held_ff <= meas_value;
        end
    end

    // output enables: whole word swaps on load, never passes through off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oe_ff <= bcd_out_pkg::LINES_OFF;
        end else begin
            oe_ff.valid <= (nxt_state == bcd_out_pkg::ST_VALID);
            if (nxt_state == bcd_out_pkg::ST_IDLE) begin
                oe_ff.data <= '0;
            end else if (load) begin
                oe_ff.data <= held_ff;
            end
        end
    end

    // open collector: the pin is only ever pulled low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_ff <= bcd_out_pkg::LINES_OFF;
        end else begin
            out_ff <= bcd_out_pkg::LINES_OFF;
        end
    end

    assign lines_out = out_ff;
    assign lines_oe = oe_ff;

    // helper counters for the checks
    logic [31:0] st_cyc_ff, valid_cyc_ff, low_cyc_ff, per_cyc_ff;
    logic valid_prev_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            valid_prev_ff <= 1'b0;
            st_cyc_ff <= 32'h0000_0000;
            valid_cyc_ff <= 32'h0000_0000;
            low_cyc_ff <= 32'h0000_0000;
            per_cyc_ff <= 32'h0000_0000;
        end else begin
            valid_prev_ff <= oe_ff.valid;
            st_cyc_ff <= restart ? 32'h0000_0000 : st_cyc_ff + 32'h0000_0001;
            valid_cyc_ff <= oe_ff.valid ? valid_cyc_ff + 32'h0000_0001 : 32'h0000_0000;
            low_cyc_ff <= oe_ff.valid ? 32'h0000_0000 : low_cyc_ff + 32'h0000_0001;
            per_cyc_ff <= (oe_ff.valid && !valid_prev_ff) ? 32'h0000_0001 : per_cyc_ff + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_idle_quiet: assert property ((state_ff == bcd_out_pkg::ST_IDLE) |-> (oe_ff == bcd_out_pkg::LINES_OFF))
        else $error("lines driven while idle");
    a_setup_delay: assert property (($rose(oe_ff.valid) && $past(state_ff) == bcd_out_pkg::ST_SETUP)
        |-> ($past(st_cyc_ff) == 32'(SETUP_CYC - 1)))
        else $error("strobe not on after setup time");
    a_valid_width: assert property ($fell(oe_ff.valid) |-> ($past(valid_cyc_ff) == 32'(VALID_CYC - 1)))
        else $error("strobe width wrong");
    a_data_stable: assert property ((oe_ff.valid && $past(oe_ff.valid)) |-> $stable(oe_ff.data))
        else $error("data moved under strobe");
    a_release_time: assert property (($past(state_ff) != bcd_out_pkg::ST_IDLE && state_ff == bcd_out_pkg::ST_IDLE)
        |-> ($past(low_cyc_ff) >= 32'(RELEASE_CYC - 1)))
        else $error("data released too early");
    a_repeat_period: assert property (($rose(oe_ff.valid) && $past(state_ff) == bcd_out_pkg::ST_GAP)
        |-> ($past(per_cyc_ff) == 32'(PERIOD_CYC - 1)))
        else $error("repeat period wrong");
    a_whole_word: assert property (($past(state_ff) == bcd_out_pkg::ST_GAP && state_ff == bcd_out_pkg::ST_VALID)
        |-> (oe_ff.data == $past(held_ff)))
        else $error("new word not presented whole");
    a_gap_keeps: assert property ((state_ff == bcd_out_pkg::ST_GAP && $past(state_ff) == bcd_out_pkg::ST_GAP)
        |-> $stable(oe_ff.data))
        else $error("data changed between words");
    a_hold_freeze: assert property ((hold_act && $past(hold_act)) |-> $stable(held_ff))
        else $error("held value moved");
    a_open_coll: assert property (out_ff == bcd_out_pkg::LINES_OFF)
        else $error("line driven high");
    a_edge_start: assert property (($past(state_ff) == bcd_out_pkg::ST_IDLE && state_ff == bcd_out_pkg::ST_SETUP)
        |-> ($past(req_rise) && !req_prev_ff))
        else $error("start without request edge");

    c_single: cover property ($past(state_ff) == bcd_out_pkg::ST_RELEASE && state_ff == bcd_out_pkg::ST_IDLE);
    c_repeat: cover property ($rose(oe_ff.valid) && $past(state_ff) == bcd_out_pkg::ST_GAP);
    c_hold_swap: cover property (hold_act && load && state_ff == bcd_out_pkg::ST_GAP);
    c_wire_low: cover property (oe_ff.valid && !lines_in.valid);
endmodule
`default_nettype wire

/* bench/bcd_reader.sv */
// reader model: a controller that requests words and captures them on the strobe
// assumes pull-ups on every port line, so a conducting transistor reads low
`timescale 1ns/1ns
`default_nettype none
module bcd_reader (
    input wire logic clk,
    input wire bcd_out_pkg::bcd_lines_t lines_oe,
    output var bcd_out_pkg::bcd_lines_t lines_in,
    output var logic request_n,
    output var logic hold_n,
    output var logic [bcd_out_pkg::DATA_W-1:0] word_ff
);
    // wire level from the pull-ups and the open collectors
    assign lines_in = ~lines_oe;
    // capture only while the strobe is seen asserted
    always_ff @(posedge clk) begin
        if (!lines_in.valid) begin
            word_ff <= ~lines_in.data;
        end
    end
    // pins are active low and change at the falling edge
    task automatic drive(input logic req, input logic hold);
        @(negedge clk);
        request_n = ~req;
        hold_n = ~hold;
    endtask
    initial begin
        request_n = 1'b1;
        hold_n = 1'b1;
    end
endmodule
`default_nettype wire

/* bench/test_bcd_result_port.sv */
// testbench for the bcd result port with a reader model on the pins
// assumes the port counts M cycles per millisecond
`timescale 1ns/1ns
`default_nettype none
module test_bcd_result_port;
    localparam int M = 10;
    logic clk;
    logic rst;
    logic [19:0] meas_value;
    bcd_out_pkg::bcd_lines_t lines_in;
    bcd_out_pkg::bcd_lines_t lines_out;
    bcd_out_pkg::bcd_lines_t lines_oe;
    logic request_n;
    logic hold_n;
    logic [19:0] word;
    int n_errors = 0;
    int tests_run = 0;
    bcd_result_port #(.MS_CYCLES(M)) DUT (.clk(clk), .rst(rst), .request_n(request_n), .hold_n(hold_n),
        .meas_value(meas_value), .lines_in(lines_in), .lines_out(lines_out), .lines_oe(lines_oe));
    bcd_reader reader (.clk(clk), .lines_oe(lines_oe), .lines_in(lines_in), .request_n(request_n),
        .hold_n(hold_n), .word_ff(word));
    // compare and count
    task automatic check(input logic [20:0] got, input logic [20:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait for the strobe to reach a level
    task automatic wait_valid(input logic lvl, output int n);
        n = 0;
        while (lines_oe.valid !== lvl && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask
    // no request, nothing conducts
    task automatic test_idle();
        repeat (100) @(negedge clk);
        check(lines_oe, 21'h0);
        check(lines_out, 21'h0);
    endtask
    // one word: setup, strobe width, release delay
    task automatic test_single();
        int n;
        meas_value = 20'h1_2345;
        reader.drive(1'b1, 1'b0);
        wait_valid(1'b1, n);
        check(21'(n >= 30 * M + 2 && n <= 30 * M + 5), 21'h1);
        check(lines_oe.data, 21'h1_2345);
        reader.drive(1'b0, 1'b0);
        wait_valid(1'b0, n);
        check(21'(n + 1), 21'(40 * M));
        check(word, 21'h1_2345);
        n = 0;
        while (lines_oe.data !== 20'h0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check(21'(n), 21'(16 * M));
        check(lines_oe, 21'h0);
    endtask
    // from one strobe rise to the next: period, no off level, word shown
    task automatic next_word(input logic [19:0] exp, input int skip);
        int n1;
        int n2;
        int zeros;
        wait_valid(1'b0, n1);
        zeros = 0;
        n2 = 0;
        while (lines_oe.valid !== 1'b1 && n2 < 2000) begin
            zeros += int'(lines_oe.data === 20'h0);
            @(negedge clk);
            n2++;
        end
        check(21'(n1 + n2 + skip), 21'(64 * M));
        check(21'(zeros), 21'h0);
        check(lines_oe.data, 21'(exp));
    endtask
    // held request repeats; hold freezes the word across a change
    task automatic test_continuous();
        int n;
        repeat (20 * M) @(negedge clk);
        meas_value = 20'h5_4321;
        reader.drive(1'b1, 1'b0);
        wait_valid(1'b1, n);
        check(lines_oe.data, 21'h5_4321);
        meas_value = 20'h6_7890;
        next_word(20'h6_7890, 0);
        reader.drive(1'b1, 1'b1);
        repeat (4) @(negedge clk);
        meas_value = 20'h1_1111;
        next_word(20'h6_7890, 5);
        reader.drive(1'b0, 1'b0);
        repeat (60 * M) @(negedge clk);
        check(lines_oe, 21'h0);
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // reset, then the scenarios
    initial begin
        rst = 1'b1;
        meas_value = 20'h9_8765;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        test_idle();
        test_single();
        test_continuous();
        finish_test();
    end
    // watchdog well past the expected run
    initial begin
        #(20 * 20000);
        n_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
